// file: src/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

	// ==========================================
	// widths and reset values
	localparam int          DATA_W     = 16;
	localparam int          CFG_W      = 16;
	localparam logic [15:0] DATA_CLEAR = 16'h0000;
	localparam logic [15:0] CFG_CLEAR  = 16'h0000;

	// ==========================================
	// positions of the control pins in the synchroniser vector
	localparam int PIN_CNT   = 6;
	localparam int PIN_CS    = 0;
	localparam int PIN_RD    = 1;
	localparam int PIN_RST   = 2;
	localparam int PIN_PD    = 3;
	localparam int PIN_TRIG  = 4;
	localparam int PIN_SCLK  = 5;

	// idle levels of the pins: selects and trigger idle high, reset held until seen
	localparam logic [5:0] PIN_IDLE = 6'h17;

	typedef enum logic [0:0] {
		CONV_IDLE,
		CONV_RUN
	} conv_state_t;

endpackage : adc_ctrl_pkg

// file: src/pin_sync.sv
module pin_sync #(
	parameter int                 WIDTH    = 1,
	parameter logic [WIDTH-1:0]   IDLE_VAL = '0
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut
);

	// ==========================================
	// two-stage synchroniser; first stage feeds only the second
	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			stage1_r <= IDLE_VAL;
			stage2_r <= IDLE_VAL;
		end
		else
		begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
		end
	end

	assign pinOut = stage2_r;

endmodule : pin_sync

// file: src/adc_control_pin_logic.sv
module adc_control_pin_logic (
	input  wire logic                               sys_clk,
	input  wire logic                               nrst,
	input  wire logic                               chipSelN,
	input  wire logic                               readStrobeN,
	input  wire logic                               resetIn,
	input  wire logic                               power_down_in,
	input  wire logic                               convert_trigger_n,
	input  wire logic                               output_coding_select,
	input  wire logic                               internal_ref_shutdown,
	input  wire logic                               ref_buffer_shutdown,
	input  wire logic                               slaveSerialMode,
	input  wire logic                               extSerialClk,
	input  wire logic                               convDone,
	input  wire logic [adc_ctrl_pkg::DATA_W-1:0]    resultData,
	input  wire logic                               cfgWrite,
	input  wire logic [adc_ctrl_pkg::CFG_W-1:0]     cfgWriteData,
	output logic                                    dataBusOe,
	output logic [adc_ctrl_pkg::DATA_W-1:0]         dataOut,
	output logic [adc_ctrl_pkg::CFG_W-1:0]          cfgReg,
	output logic                                    holdSample,
	output logic                                    convStart,
	output logic                                    convAbort,
	output logic                                    convBusy,
	output logic                                    coreReset,
	output logic                                    powerDownActive,
	output logic                                    refEnable,
	output logic                                    bufEnable,
	output logic                                    gatedSerialClk
);

	// ==========================================
	// pin synchronisation
	logic [adc_ctrl_pkg::PIN_CNT-1:0] pinRaw;
	logic [adc_ctrl_pkg::PIN_CNT-1:0] pinSync;

	assign pinRaw[adc_ctrl_pkg::PIN_CS]   = chipSelN;
	assign pinRaw[adc_ctrl_pkg::PIN_RD]   = readStrobeN;
	assign pinRaw[adc_ctrl_pkg::PIN_RST]  = resetIn;
	assign pinRaw[adc_ctrl_pkg::PIN_PD]   = power_down_in;
	assign pinRaw[adc_ctrl_pkg::PIN_TRIG] = convert_trigger_n;
	assign pinRaw[adc_ctrl_pkg::PIN_SCLK] = extSerialClk;

	pin_sync #(
		.WIDTH    (adc_ctrl_pkg::PIN_CNT),
		.IDLE_VAL (adc_ctrl_pkg::PIN_IDLE)
	) u_pin_sync (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.pinIn   (pinRaw),
		.pinOut  (pinSync)
	);

	logic csN;
	logic rdN;
	logic rstHi;
	logic pdHi;
	logic trigN;
	logic sclk;

	assign csN   = pinSync[adc_ctrl_pkg::PIN_CS];
	assign rdN   = pinSync[adc_ctrl_pkg::PIN_RD];
	assign rstHi = pinSync[adc_ctrl_pkg::PIN_RST];
	assign pdHi  = pinSync[adc_ctrl_pkg::PIN_PD];
	assign trigN = pinSync[adc_ctrl_pkg::PIN_TRIG];
	assign sclk  = pinSync[adc_ctrl_pkg::PIN_SCLK];

	// ==========================================
	// edge detection on synchronised levels
	logic trigPrev_r;
	logic rstPrev_r;
	logic trigFall;
	logic rstFall;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			trigPrev_r <= 1'h1;
			rstPrev_r  <= 1'h1;
		end
		else
		begin
			trigPrev_r <= trigN;
			rstPrev_r  <= rstHi;
		end
	end

	assign trigFall = trigPrev_r & ~trigN;
	assign rstFall  = rstPrev_r & ~rstHi;

	// ==========================================
	// conversion sequencing
	adc_ctrl_pkg::conv_state_t state_r;
	adc_ctrl_pkg::conv_state_t state_nxt;
	logic                      startOk;

	assign startOk = trigFall & ~rstHi & ~pdHi;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			adc_ctrl_pkg::CONV_IDLE:
			begin
				if (startOk)
					state_nxt = adc_ctrl_pkg::CONV_RUN;
			end
			adc_ctrl_pkg::CONV_RUN:
			begin
				if (rstHi)
					state_nxt = adc_ctrl_pkg::CONV_IDLE;
				else if (convDone)
					state_nxt = adc_ctrl_pkg::CONV_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			state_r <= adc_ctrl_pkg::CONV_IDLE;
		else
			state_r <= state_nxt;
	end

	assign convBusy        = (state_r == adc_ctrl_pkg::CONV_RUN);
	assign holdSample      = convBusy;
	assign convStart       = (state_r == adc_ctrl_pkg::CONV_IDLE) & startOk;
	assign convAbort       = convBusy & rstHi;
	assign coreReset       = rstHi;
	assign powerDownActive = pdHi;

	// ==========================================
	// result and configuration registers
	logic resultLoad;

	// a result arriving while reset is high belongs to an aborted conversion
	assign resultLoad = convBusy & convDone & ~rstHi;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			dataOut <= adc_ctrl_pkg::DATA_CLEAR;
		else if (rstFall & output_coding_select)
			dataOut <= adc_ctrl_pkg::DATA_CLEAR;
		else if (resultLoad)
			dataOut <= resultData;
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			cfgReg <= adc_ctrl_pkg::CFG_CLEAR;
		else if (rstFall)
			cfgReg <= adc_ctrl_pkg::CFG_CLEAR;
		else if (cfgWrite & ~rstHi)
			cfgReg <= cfgWriteData;
	end

	// ==========================================
	// host-facing enables
	// bus enable
	assign dataBusOe = ~csN & ~rdN;
	assign gatedSerialClk = slaveSerialMode & ~csN & sclk;
	assign refEnable = ~internal_ref_shutdown;
	assign bufEnable = ~ref_buffer_shutdown;

	// ==========================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// pins seen two edges late, so the synchroniser path is checked too
	bus_enable_a: assert property (
		dataBusOe == (!$past(chipSelN, 2) && !$past(readStrobeN, 2)))
		else $error("bus enable does not follow select and strobe");

	sclk_gate_a: assert property (
		(csN || !slaveSerialMode) |-> !gatedSerialClk)
		else $error("serial clock passed while deselected");

	reset_abort_a: assert property (
		(convBusy && rstHi) |=> !convBusy)
		else $error("conversion survived reset");

	cfg_clear_a: assert property (
		rstFall |=> (cfgReg == adc_ctrl_pkg::CFG_CLEAR))
		else $error("configuration not cleared on reset release");

	data_zero_a: assert property (
		(rstFall && output_coding_select) |=> (dataOut == adc_ctrl_pkg::DATA_CLEAR))
		else $error("data not zeroed on reset release");

	pd_finish_a: assert property (
		(convBusy && pdHi && convDone && !rstHi) |=> (!convBusy && dataOut == $past(resultData)))
		else $error("conversion not finished in power-down");

	pd_block_a: assert property (
		(pdHi || rstHi) |-> !convStart)
		else $error("conversion started while blocked");

	pd_cfg_a: assert property (
		(pdHi && !rstHi && cfgWrite && !rstFall) |=> (cfgReg == $past(cfgWriteData)))
		else $error("configuration write lost in power-down");

	trig_start_a: assert property (
		(!convBusy && trigFall && !pdHi && !rstHi) |-> convStart ##1 (convBusy && holdSample))
		else $error("trigger edge did not start conversion");

	ref_sel_a: assert property (
		(internal_ref_shutdown == ref_buffer_shutdown) |-> (refEnable == bufEnable
			&& refEnable == !internal_ref_shutdown))
		else $error("reference enables wrong");

	conv_cov: cover property (convStart ##[1:20] resultLoad);
	abort_cov: cover property (convBusy ##1 convAbort);
	pd_cov: cover property (convBusy && pdHi ##[1:20] !convBusy);
	read_cov: cover property (resultLoad ##[1:20] dataBusOe);

endmodule : adc_control_pin_logic

// file: test/host_model.sv
module host_model (
	input  wire logic sys_clk,
	output logic      convert_trigger_n
);
	timeunit 1ns;
	timeprecision 100ps;
	initial convert_trigger_n = 1'h1;
	task automatic pulse(input int lowCycles);
		@(negedge sys_clk);
		convert_trigger_n = 1'h0;
		repeat (lowCycles) @(negedge sys_clk);
		// high again so the next fall is a fresh edge
		convert_trigger_n = 1'h1;
	endtask : pulse
endmodule : host_model

// file: test/adc_control_pin_logic_bench.sv
module adc_control_pin_logic_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        sys_clk = 1'h0, nrst = 1'h0, chipSelN = 1'h1, readStrobeN = 1'h1;
	logic        resetIn = 1'h0, power_down_in = 1'h0, output_coding_select = 1'h0;
	logic        internal_ref_shutdown = 1'h0, ref_buffer_shutdown = 1'h0;
	logic        slaveSerialMode = 1'h0, extSerialClk = 1'h0, convDone = 1'h0, cfgWrite = 1'h0;
	logic [15:0] resultData = 16'h0000, cfgWriteData = 16'h0000, dataOut, cfgReg;
	logic        convert_trigger_n, dataBusOe, holdSample, convStart, convAbort, convBusy;
	logic        powerDownActive, refEnable, bufEnable, gatedSerialClk, seen, coreReset;
	int          errors = 0, total_checks = 0, cyc = 0, seed = 32'hcc88, mData, mCfg;
	int          pend[$];

	host_model host (.sys_clk, .convert_trigger_n);
	adc_control_pin_logic dut (.sys_clk, .nrst, .chipSelN, .readStrobeN, .resetIn,
		.power_down_in, .convert_trigger_n, .output_coding_select, .internal_ref_shutdown,
		.ref_buffer_shutdown, .slaveSerialMode, .extSerialClk, .convDone, .resultData,
		.cfgWrite, .cfgWriteData, .dataBusOe, .dataOut, .cfgReg, .holdSample, .convStart,
		.convAbort, .convBusy, .coreReset, .powerDownActive, .refEnable, .bufEnable,
		.gatedSerialClk);

	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errors++;
			tally_and_finish();
		end
	end

	// ==========
	// tasks
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : step

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	// slow core: a few cycles pass so a mid-run power-down is seen first
	task automatic conv(input logic ok, input logic pdMid);
		seen = 1'h0;
		fork
			host.pulse(2 + ($unsigned($random(seed)) % 3));
			repeat (6)
			begin
				step(1);
				if (convStart === 1'h1)
					seen = 1'h1;
			end
		join
		chk("start", 16'(seen), 16'(ok));
		if (ok)
		begin
			power_down_in = pdMid;
			chk("hold", 16'(holdSample), 16'h0001);
			step(3);
			pend.push_back($unsigned($random(seed)) & 16'hffff);
			resultData = 16'(pend[0]);
			convDone = 1'h1;
			step(1);
			convDone = 1'h0;
			step(1);
			mData = pend.pop_front();
			chk("data", dataOut, 16'(mData));
			chk("busy", 16'(convBusy), 16'h0000);
		end
	endtask : conv

	// ==========
	// scenarios
	initial
	begin
		step(3);
		nrst = 1'h1;
		step(6);
		chk("cfgInit", cfgReg, 16'h0000);
		for (int i = 0; i < 8; i++)
		begin
			{chipSelN, readStrobeN} = 2'(i);
			{internal_ref_shutdown, ref_buffer_shutdown} = 2'(i);
			slaveSerialMode = i[2];
			extSerialClk = 1'($random(seed));
			step(3);
			chk("busOe", 16'(dataBusOe), 16'(!(chipSelN | readStrobeN)));
			chk("refBuf", 16'({refEnable, bufEnable}), 16'(~i & 3));
			chk("sclk", 16'(gatedSerialClk), 16'(extSerialClk & ~chipSelN & i[2]));
		end
		$display("pin test done");
		conv(1'h1, 1'h0);
		conv(1'h1, 1'h1);
		chk("pdSeen", 16'(powerDownActive), 16'h0001);
		mCfg = $unsigned($random(seed)) & 16'hffff;
		cfgWriteData = 16'(mCfg);
		cfgWrite = 1'h1;
		step(1);
		cfgWrite = 1'h0;
		step(1);
		chk("cfgPd", cfgReg, 16'(mCfg));
		{chipSelN, readStrobeN} = 2'h0;
		step(3);
		chk("oePd", 16'(dataBusOe), 16'h0001);
		conv(1'h0, 1'h0);
		power_down_in = 1'h0;
		step(4);
		chk("noQueue", 16'(convBusy), 16'h0000);
		conv(1'h1, 1'h0);
		$display("power-down test done");
		fork
			host.pulse(2);
			step(5);
		join
		chk("run", 16'(convBusy), 16'h0001);
		resetIn = 1'h1;
		seen = 1'h0;
		repeat (4)
		begin
			step(1);
			if (convAbort === 1'h1)
				seen = 1'h1;
		end
		chk("abort", 16'(seen), 16'h0001);
		chk("aborted", 16'(convBusy), 16'h0000);
		chk("coreRst", 16'(coreReset), 16'h0001);
		conv(1'h0, 1'h0);
		output_coding_select = 1'h1;
		resetIn = 1'h0;
		step(4);
		mData = 0;
		mCfg = 0;
		chk("dataClr", dataOut, 16'(mData));
		chk("cfgClr", cfgReg, 16'(mCfg));
		chk("coreRel", 16'(coreReset), 16'h0000);
		chk("idle", 16'(convBusy), 16'h0000);
		conv(1'h1, 1'h0);
		$display("reset test done");
		tally_and_finish();
	end
endmodule : adc_control_pin_logic_bench
